// file: verilog/epp_consts.svh
`ifndef EPP_CONSTS_SVH
`define EPP_CONSTS_SVH
`define EPP_CLK_PERIOD_NS 8
`define EPP_T_PULSE_NS 100000
`define EPP_T_PULSE_MIN_NS 95000
`define EPP_T_PULSE_MAX_NS 105000
`define EPP_T_SETUP_NS 2000
`define EPP_T_FLOAT_NS 130
`define EPP_PULSE_CYC ((`EPP_T_PULSE_NS + `EPP_CLK_PERIOD_NS - 1) / `EPP_CLK_PERIOD_NS)
`define EPP_PULSE_MIN_CYC ((`EPP_T_PULSE_MIN_NS + `EPP_CLK_PERIOD_NS - 1) / `EPP_CLK_PERIOD_NS)
`define EPP_PULSE_MAX_CYC (`EPP_T_PULSE_MAX_NS / `EPP_CLK_PERIOD_NS)
`define EPP_SETUP_CYC ((`EPP_T_SETUP_NS + `EPP_CLK_PERIOD_NS - 1) / `EPP_CLK_PERIOD_NS)
`define EPP_FLOAT_CYC ((`EPP_T_FLOAT_NS + `EPP_CLK_PERIOD_NS - 1) / `EPP_CLK_PERIOD_NS)
`define EPP_MAX_PULSES 25
`define EPP_MFR_ID 8'h5a
`define EPP_DEV_ID 8'ha5
`define EPP_SIG_ADDR_MFR 19'h00000
`define EPP_SIG_ADDR_DEV 19'h00001
`define EPP_ERASED_BYTE 8'hff
`endif

// file: verilog/epp_pkg.sv
package epp_pkg;
  typedef enum logic {OP_SIGNATURE, OP_PROGRAM} epp_op_e;
  typedef struct packed {
    epp_op_e op;
    logic [18:0] first_addr;
    logic [18:0] last_addr;
  } epp_cmd_s;
  typedef struct packed {
    logic fail;
    logic sig_ok;
    logic [18:0] fail_addr;
    logic [7:0] mfr_id;
    logic [7:0] dev_id;
  } epp_status_s;
  typedef struct packed {
    logic [18:0] addr;
    logic ce_n;
    logic oe_n;
    logic [7:0] data_o;
    logic data_oe;
    logic vpp_hi;
    logic vcc_hi;
    logic signature_hv_line;
  } epp_pins_s;
endpackage

// file: verilog/epp_programmer.sv
`include "epp_consts.svh"
module epp_programmer #(
  parameter int PULSE_CYC = `EPP_PULSE_CYC,
  parameter int SETUP_CYC = `EPP_SETUP_CYC,
  parameter int MAX_PULSES = `EPP_MAX_PULSES,
  parameter logic [7:0] MFR_ID = `EPP_MFR_ID, // Arbitrary value
  parameter logic [7:0] DEV_ID = `EPP_DEV_ID // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire epp_pkg::epp_cmd_s cmd,
  output logic [18:0] fetch_addr,
  input wire logic [7:0] fetch_data,
  output logic done,
  output epp_pkg::epp_status_s status,
  output epp_pkg::epp_pins_s pins,
  input wire logic [7:0] data_pins_i
);
  localparam int FLOAT_CYC = `EPP_FLOAT_CYC;
  localparam int CNT_W = 16;

  if (PULSE_CYC < 1 || PULSE_CYC >= (1 << CNT_W) - FLOAT_CYC || SETUP_CYC < 3 || MAX_PULSES < 1
      || MAX_PULSES > 255 || SETUP_CYC > 299)
  begin : g_bad_param
    $error("epp_programmer: parameter out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_SIG_LO, ST_SIG_HI, ST_PRG_SET, ST_PRG_PULSE, ST_PRG_HOLD,
    ST_VFY} epp_state_e;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  // Readback synchroniser
  logic [7:0] sync1_q, sync2_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end
    else
    begin
      sync1_q <= data_pins_i;
      sync2_q <= sync1_q;
    end
  end

  epp_state_e state_q, state_d;
  logic [CNT_W-1:0] timer_q, timer_d;
  logic [7:0] pulses_q, pulses_d;
  logic [18:0] last_q, last_d;
  logic done_q, done_d;
  epp_pkg::epp_status_s stat_q, stat_d;
  epp_pkg::epp_pins_s pins_q, pins_d;
  logic vfy_pass;

  assign vfy_pass = (state_q == ST_VFY) && (timer_q == '0) && (sync2_q == pins_q.data_o);

  always_comb
  begin
    state_d = state_q;
    timer_d = (timer_q != '0) ? timer_q - cyc(1) : timer_q;
    pulses_d = pulses_q;
    last_d = last_q;
    done_d = 1'b0;
    stat_d = stat_q;
    pins_d = pins_q;
    unique case (state_q)
      ST_IDLE:
      begin
        pins_d = '0;
        pins_d.ce_n = 1'b1;
        pins_d.oe_n = 1'b1;
        if (cmd_valid)
        begin
          stat_d.fail = 1'b0;
          if (cmd.op == epp_pkg::OP_SIGNATURE)
          begin
            pins_d.signature_hv_line = 1'b1;
            pins_d.addr = `EPP_SIG_ADDR_MFR;
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0;
            timer_d = cyc(SETUP_CYC);
            state_d = ST_SIG_LO;
          end
          else if (!stat_q.sig_ok)
          begin
            stat_d.fail = 1'b1;
            stat_d.fail_addr = cmd.first_addr;
            done_d = 1'b1;
          end
          else
          begin
            pins_d.addr = cmd.first_addr;
            pins_d.vpp_hi = 1'b1;
            pins_d.vcc_hi = 1'b1;
            last_d = cmd.last_addr;
            pulses_d = 8'h00;
            timer_d = cyc(SETUP_CYC + FLOAT_CYC);
            state_d = ST_PRG_SET;
          end
        end
      end
      ST_SIG_LO:
        if (timer_q == '0)
        begin
          stat_d.mfr_id = sync2_q;
          pins_d.addr = `EPP_SIG_ADDR_DEV;
          timer_d = cyc(SETUP_CYC);
          state_d = ST_SIG_HI;
        end
      ST_SIG_HI:
        if (timer_q == '0)
        begin
          stat_d.dev_id = sync2_q;
          stat_d.sig_ok = (stat_q.mfr_id == MFR_ID) && (sync2_q == DEV_ID);
          done_d = 1'b1;
          state_d = ST_IDLE;
          pins_d.signature_hv_line = 1'b0;
          pins_d.addr = '0;
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
        end
      ST_PRG_SET:
      begin
        // Wait out device output float before driving data
        pins_d.data_o = fetch_data;
        pins_d.data_oe = timer_q <= cyc(SETUP_CYC);
        if (timer_q == '0)
        begin
          pins_d.ce_n = 1'b0;
          pulses_d = pulses_q + 8'h01;
          timer_d = cyc(PULSE_CYC - 1);
          state_d = ST_PRG_PULSE;
        end
      end
      ST_PRG_PULSE:
        if (timer_q == '0)
        begin
          pins_d.ce_n = 1'b1;
          timer_d = cyc(SETUP_CYC);
          state_d = ST_PRG_HOLD;
        end
      ST_PRG_HOLD:
        if (timer_q == '0)
        begin
          pins_d.data_oe = 1'b0;
          pins_d.oe_n = 1'b0;
          timer_d = cyc(SETUP_CYC);
          state_d = ST_VFY;
        end
      ST_VFY:
        if (timer_q == '0)
        begin
          pins_d.oe_n = 1'b1;
          if (vfy_pass && pins_q.addr == last_q)
          begin
            done_d = 1'b1;
            state_d = ST_IDLE;
          end
          else if (vfy_pass)
          begin
            pins_d.addr = pins_q.addr + 19'h00001;
            pulses_d = 8'h00;
            timer_d = cyc(SETUP_CYC + FLOAT_CYC);
            state_d = ST_PRG_SET;
          end
          else if (pulses_q == 8'(MAX_PULSES))
          begin
            stat_d.fail = 1'b1;
            stat_d.fail_addr = pins_q.addr;
            done_d = 1'b1;
            state_d = ST_IDLE;
          end
          else
          begin
            timer_d = cyc(SETUP_CYC + FLOAT_CYC);
            state_d = ST_PRG_SET;
          end
        end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      timer_q <= '0;
      pulses_q <= 8'h00;
      last_q <= '0;
      done_q <= 1'b0;
      stat_q <= '0;
      pins_q <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, data_o: `EPP_ERASED_BYTE, default: '0};
    end
    else
    begin
      state_q <= state_d;
      timer_q <= timer_d;
      pulses_q <= pulses_d;
      last_q <= last_d;
      done_q <= done_d;
      stat_q <= stat_d;
      pins_q <= pins_d;
    end
  end

  assign cmd_ready = state_q == ST_IDLE;
  assign fetch_addr = pins_q.addr;
  assign done = done_q;
  assign status = stat_q;
  assign pins = pins_q;

  // Low-time counter of the select pin, checking aid only
  logic [CNT_W-1:0] low_len_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst || pins_q.ce_n)
      low_len_q <= '0;
    else
      low_len_q <= low_len_q + cyc(1);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_pulse_end;
    $rose(pins_q.ce_n) && pins_q.vpp_hi;
  endsequence
  sequence s_verify_window;
    !pins_q.oe_n && !pins_q.signature_hv_line;
  endsequence

  pulse_width_a: assert property (s_pulse_end |-> $past(low_len_q) == cyc(PULSE_CYC - 1))
    else $error("program pulse width wrong");
  prog_levels_a: assert property (!pins_q.ce_n && pins_q.vpp_hi |-> pins_q.data_oe && pins_q.oe_n)
    else $error("program pulse without data or with gate low");
  verify_levels_a: assert property (s_verify_window |-> pins_q.ce_n && pins_q.vpp_hi && pins_q.vcc_hi)
    else $error("verify levels wrong");
  sig_levels_a: assert property (pins_q.signature_hv_line |->
    !pins_q.vpp_hi && !pins_q.vcc_hi && pins_q.addr[18:1] == 18'h0)
    else $error("signature levels wrong");
  no_contention_a: assert property (pins_q.data_oe |-> pins_q.oe_n && $past(pins_q.oe_n))
    else $error("data driven against device");
  pulse_bound_a: assert property (pulses_q <= 8'(MAX_PULSES))
    else $error("pulse count over limit");
  no_overprogram_a: assert property (vfy_pass |=> pulses_q == 8'h00 || state_q == ST_IDLE)
    else $error("pulse after good verify");
  addr_step_a: assert property (state_q != ST_IDLE && $past(state_q) != ST_IDLE &&
    !pins_q.signature_hv_line && $changed(pins_q.addr) |-> pins_q.addr == $past(pins_q.addr) + 19'h00001)
    else $error("address skipped");
  verify_after_pulse_a: assert property (s_pulse_end |-> ##(SETUP_CYC + 1) s_verify_window)
    else $error("no verify after pulse");
endmodule

// file: sim/epp_eprom_model.sv
module epp_eprom_model #(
  parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'ha5, // Arbitrary value
  parameter int PULSE_CYC = 20
) (
  input wire logic clk_sys,
  input wire epp_pkg::epp_pins_s pins,
  output logic [7:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [8];
  int pulses [8];
  int bad_width = 0;
  int sig_addr_err = 0;
  int low_cyc = 0;
  logic [7:0] val;
  logic drv;
  logic [7:0] last_q = 8'h00;
  logic [2:0] a;
  assign a = pins.addr[2:0];
  // Weak cell at 3 needs two pulses, cell at 5 needs 99 pulses to reach margin
  function automatic int need(input logic [2:0] x);
    return (x == 3'h3) ? 2 : (x == 3'h5) ? 99 : 1;
  endfunction
  initial
  begin
    foreach (mem[i])
    begin
      mem[i] = 8'hff;
      pulses[i] = 0;
    end
  end
  always @(posedge clk_sys)
  begin
    if (drv)
      last_q <= val;
    if (pins.signature_hv_line && pins.addr[18:1] != 18'h0)
      sig_addr_err++;
    if (!pins.ce_n)
      low_cyc++;
    else if (low_cyc != 0)
    begin
      if (pins.vpp_hi && pins.vcc_hi && pins.data_oe)
      begin
        pulses[a]++;
        if (low_cyc != PULSE_CYC)
          bad_width++;
        if (pulses[a] >= need(a))
          mem[a] &= pins.data_o;
      end
      low_cyc = 0;
    end
  end
  always_comb
  begin
    drv = 1'b0;
    val = mem[a];
    if (!pins.oe_n && !pins.ce_n && pins.signature_hv_line && !pins.vpp_hi)
    begin
      drv = 1'b1;
      val = pins.addr[0] ? DEV_ID : MFR_ID;
    end
    else if (!pins.oe_n && (!pins.ce_n || pins.vpp_hi))
      drv = 1'b1;
  end
  // Released bus shows the inverse of the last value
  assign bus_o = drv ? val : ~last_q;
endmodule

// file: sim/test_eprom_program_verify_signature.sv
module test_eprom_program_verify_signature;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  epp_pkg::epp_cmd_s cmd = '0;
  logic [7:0] fetch_data = 8'h00;
  logic cmd_ready;
  logic done;
  logic [18:0] fetch_addr;
  epp_pkg::epp_status_s status;
  epp_pkg::epp_pins_s pins;
  logic [7:0] data_pins_i;
  logic [7:0] bus_o;
  int fails = 0;
  int num_checks = 0;
  epp_programmer #(.PULSE_CYC(20), .SETUP_CYC(4), .MAX_PULSES(3)) dut (.clk_sys(clk_sys), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .fetch_addr(fetch_addr),
    .fetch_data(fetch_data), .done(done), .status(status), .pins(pins), .data_pins_i(data_pins_i));
  epp_eprom_model #(.PULSE_CYC(20)) mdl (.clk_sys(clk_sys), .pins(pins), .bus_o(bus_o));
  assign data_pins_i = pins.data_oe ? pins.data_o : bus_o;
  function automatic logic [7:0] pat(input logic [18:0] x);
    return 8'hc3 ^ {5'h00, x[2:0]};
  endfunction
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    fetch_data <= pat(fetch_addr);
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic run(input epp_pkg::epp_op_e op, input logic [18:0] f, input logic [18:0] l);
    int n;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{op, f, l};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    for (n = 0; n < 5000 && done !== 1'b1; n++)
      @(negedge clk_sys);
    if (done !== 1'b1)
    begin
      fails++;
      $display("[FAIL] %0t command never finished", $time);
      conclude();
    end
  endtask
  task automatic t_refused;
    run(epp_pkg::OP_PROGRAM, 19'h00001, 19'h00001);
    chk(status.fail, 1'b1, "refused flag");
    chk(status.fail_addr, 19'h00001, "refused addr");
    chk(mdl.pulses[1], 0, "refused pulses");
    chk(cmd_ready, 1'b1, "ready after refusal");
  endtask
  task automatic t_signature;
    run(epp_pkg::OP_SIGNATURE, 19'h00000, 19'h00000);
    chk(status.sig_ok, 1'b1, "signature ok");
    chk(status.mfr_id, 8'h5a, "maker byte");
    chk(status.dev_id, 8'ha5, "device byte");
    chk(mdl.sig_addr_err, 0, "signature address");
  endtask
  task automatic t_program;
    run(epp_pkg::OP_PROGRAM, 19'h00002, 19'h00004);
    chk(status.fail, 1'b0, "program flag");
    for (int i = 2; i <= 4; i++)
      chk(mdl.mem[i], pat(19'(i)), "programmed byte");
    chk(mdl.pulses[2], 1, "pulses at 2");
    chk(mdl.pulses[3], 2, "pulses at 3");
    chk(mdl.pulses[4], 1, "pulses at 4");
    chk(mdl.mem[1], 8'hff, "neighbour byte");
    chk(mdl.bad_width, 0, "pulse width");
    chk(fetch_addr, 19'h00004, "last address");
    @(negedge clk_sys);
    chk(pins.vpp_hi, 1'b0, "rail after program");
  endtask
  task automatic t_limit;
    run(epp_pkg::OP_PROGRAM, 19'h00005, 19'h00006);
    chk(status.fail, 1'b1, "limit flag");
    chk(status.fail_addr, 19'h00005, "limit addr");
    chk(mdl.pulses[5], 3, "limit pulses");
    chk(mdl.pulses[6], 0, "no advance");
    chk(mdl.bad_width, 0, "pulse width");
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_refused();
    t_signature();
    t_program();
    t_limit();
    conclude();
  end
endmodule
